// ===== inc/hlpr_map.svh
/*
 Register offsets, field layout, reset values and the control-list-filled bit
 position of the list pointer register bank.
 Assumes a 32-bit register read port addressed by byte offset from the memory base.
*/
`ifndef HLPR_MAP_SVH
`define HLPR_MAP_SVH

`define HLPR_PERIODIC_CUR_OFS 8'h1c
`define HLPR_CTRL_HEAD_OFS 8'h20
`define HLPR_CTRL_CUR_OFS 8'h24
`define HLPR_PTR_RESET 32'h0000_0000
`define HLPR_PTR_LSB 4
`define HLPR_RSVD_BITS 4
`define HLPR_CLF_BIT 1

`endif

// ===== inc/hlpr_pkg.sv
/*
 Types shared by the list pointer register bank.
 Assumes hlpr_map.svh supplies the numeric constants.
*/
package hlpr_pkg;
    typedef logic [27:0] hlpr_addr_t;
endpackage : hlpr_pkg

// ===== rtl/hlpr_list_ptr_regs.sv
/*
 List pointer register bank of a USB open host controller: periodic current
 pointer, control head pointer and control current pointer, with read port.
 Assumes the list walker runs on clk and pulses its update strobes for one cycle;
 reset rstn is asynchronous active low and is released through two flip-flops here.
*/
// Functional notes
// - Read-only periodic current pointer at 1Ch, address in bits 31..4.
// - Each frame the periodic pointer names the periodic list head to process.
// - Hardware updates the periodic pointer after each periodic descriptor.
// - Reads return the instantaneous pointer value; pointer resets to zero.
// - Control head pointer at 20h, address in bits 31..4.
// - Control list traversal starts from the control head pointer.
// - Control head is loaded from the shared comm area during initialisation.
// - Control current pointer at 24h, all bits reset to zero.
// - Control current advances per descriptor and resumes next frame.
// - At list end, if filled flag set reload from head and clear flag.
`timescale 1ns/1ps
`include "hlpr_map.svh"

module hlpr_list_ptr_regs
    import hlpr_pkg::*;
#(
    parameter int PTR_W = 32,
    parameter int RSVD_W = `HLPR_RSVD_BITS
)
(
    input wire logic clk,
    input wire logic rstn,
    // Register read port
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    output logic [31:0] rd_data,
    output logic rd_valid,
    // Periodic list walker
    input wire logic frame_start,
    input wire hlpr_addr_t periodic_head_addr,
    input wire logic periodic_done,
    input wire hlpr_addr_t periodic_next_addr,
    // Control head loading at initialisation
    input wire logic init_load,
    input wire hlpr_addr_t shared_comm_area_head,
    // Control list walker
    input wire logic control_done,
    input wire hlpr_addr_t control_next_addr,
    input wire logic control_list_end,
    input wire logic control_list_filled_flag,
    output logic control_list_filled_clear,
    // Driver write of the control current pointer, then the three pointer outputs
    input wire logic control_list_enable,
    input wire logic cur_wr_en,
    input wire hlpr_addr_t cur_wr_addr,
    output logic [31:0] periodic_current_addr,
    output logic [31:0] control_head_addr,
    output logic [31:0] control_current_addr
);

    logic rst_sync1_reg;
    logic rst_sync2_reg;
    logic rst_n;
    hlpr_addr_t periodic_current_reg;
    hlpr_addr_t control_head_reg;
    hlpr_addr_t control_current_reg;
    logic [31:0] rd_data_reg;
    logic rd_valid_reg;
    logic clf_clear_reg;

    // The pointer word is fixed by the address type; other splits cannot be served
    if (PTR_W != 32 || RSVD_W != `HLPR_RSVD_BITS || $bits(hlpr_addr_t) + RSVD_W != PTR_W) begin : g_width_check
        $error("hlpr_list_ptr_regs: unsupported pointer width split");
    end

    function automatic logic [31:0] hlpr_word(input hlpr_addr_t a);
        hlpr_word = {a, {`HLPR_RSVD_BITS{1'b0}}};
    endfunction : hlpr_word

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync1_reg <= 1'b0;
            rst_sync2_reg <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_sync2_reg <= rst_sync1_reg;
        end
    end
    assign rst_n = rst_sync2_reg;

    // Frame start wins over a descriptor completion in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            periodic_current_reg <= '0;
        end else if (frame_start) begin
            periodic_current_reg <= periodic_head_addr;
        end else if (periodic_done) begin
            periodic_current_reg <= periodic_next_addr;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            control_head_reg <= '0;
        end else if (init_load) begin
            control_head_reg <= shared_comm_area_head;
        end
    end

    // Current pointer is not touched at frame start, so the walk resumes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            control_current_reg <= '0;
        end else if (control_list_end) begin
            if (control_list_filled_flag) begin
                control_current_reg <= control_head_reg;
            end
        end else if (control_done) begin
            control_current_reg <= control_next_addr;
        end else if (cur_wr_en && !control_list_enable) begin
            control_current_reg <= cur_wr_addr;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clf_clear_reg <= 1'b0;
        end else begin
            clf_clear_reg <= control_list_end && control_list_filled_flag;
        end
    end

    // Read data is sampled on the request edge, so it is the live value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_reg <= `HLPR_PTR_RESET;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= rd_en;
            if (rd_en) begin
                unique case (rd_addr)
                    `HLPR_PERIODIC_CUR_OFS: rd_data_reg <= hlpr_word(periodic_current_reg);
                    `HLPR_CTRL_HEAD_OFS: rd_data_reg <= hlpr_word(control_head_reg);
                    `HLPR_CTRL_CUR_OFS: rd_data_reg <= hlpr_word(control_current_reg);
                    default: rd_data_reg <= `HLPR_PTR_RESET;
                endcase
            end
        end
    end

    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;
    assign control_list_filled_clear = clf_clear_reg;
    assign periodic_current_addr = hlpr_word(periodic_current_reg);
    assign control_head_addr = hlpr_word(control_head_reg);
    assign control_current_addr = hlpr_word(control_current_reg);

endmodule : hlpr_list_ptr_regs

// ===== bench/hlpr_list_assertions.sv
/* Port checker of the list pointer bank.
   Assumes hlpr_pkg is compiled first and is bound at the foot. */
`timescale 1ns/1ps
module hlpr_list_assertions
    import hlpr_pkg::*;
(
    input wire logic clk, rstn, rd_en, rd_valid, frame_start, periodic_done, control_done,
    input wire logic control_list_end, control_list_filled_flag, control_list_filled_clear,
    input wire logic [7:0] rd_addr,
    input wire hlpr_addr_t periodic_head_addr, periodic_next_addr, control_next_addr,
    input wire logic [31:0] rd_data, periodic_current_addr, control_head_addr,
    input wire logic [31:0] control_current_addr
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_refill;
        control_list_end && control_list_filled_flag;
    endsequence
    chk_read_answer: assert property (rd_en |=> rd_valid) else $error("no answer");
    chk_read_live: assert property (rd_en && rd_addr == 8'h24
        |=> rd_data == $past(control_current_addr)) else $error("stale read");
    chk_frame_head: assert property (frame_start
        |=> periodic_current_addr[31:4] == $past(periodic_head_addr)) else $error("head");
    chk_periodic_step: assert property (periodic_done && !frame_start
        |=> periodic_current_addr[31:4] == $past(periodic_next_addr)) else $error("step");
    chk_ctrl_step: assert property (control_done && !control_list_end
        |=> control_current_addr[31:4] == $past(control_next_addr)) else $error("advance");
    chk_refill_ptr: assert property (s_refill
        |=> control_current_addr == control_head_addr) else $error("refill");
    chk_clear_pulse: assert property (s_refill
        |=> control_list_filled_clear ##1 !control_list_filled_clear) else $error("clear");
    chk_end_idle: assert property (control_list_end && !control_list_filled_flag
        |=> !control_list_filled_clear && $stable(control_current_addr)) else $error("idle");
    chk_rsvd_zero: assert property (((periodic_current_addr | control_head_addr
        | control_current_addr) & 32'hf) == 32'h0) else $error("low bits");
endmodule : hlpr_list_assertions
bind hlpr_list_ptr_regs hlpr_list_assertions hlpr_list_assertions_inst (.*);

// ===== bench/hlpr_drv_model.sv
/* Driver software model: register reads at the falling edge.
   Assumes a one-cycle read answer. */
`timescale 1ns/1ps
module hlpr_drv_model (
    input wire logic clk,
    input wire logic rd_valid,
    input wire logic [31:0] rd_data,
    output logic rd_en,
    output logic [7:0] rd_addr
);
    initial {rd_en, rd_addr} = '0;
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic ok);
        @(negedge clk) {rd_en, rd_addr} = {1'b1, a};
        // Released offset toggles so nothing leans on a stale address
        @(negedge clk) {rd_en, rd_addr} = {1'b0, ~a};
        {ok, d} = {rd_valid, rd_data};
    endtask : rd
endmodule : hlpr_drv_model

// ===== bench/tb_top.sv
/* Random bench of the list pointer bank.
   Assumes the checker binds itself to the bank. */
`timescale 1ns/1ps
module tb_top;
    import hlpr_pkg::*;
    logic clk, rstn, rd_en, rd_valid, cur_wr_en, control_list_enable, control_list_filled_flag;
    logic frame_start, periodic_done, init_load, control_done, control_list_end, ok;
    logic control_list_filled_clear;
    logic [5:0] stb;
    logic [7:0] rd_addr;
    logic [31:0] rd_data, periodic_current_addr, control_head_addr, control_current_addr, d, cc;
    hlpr_addr_t periodic_head_addr, periodic_next_addr, shared_comm_area_head, control_next_addr;
    hlpr_addr_t cur_wr_addr;
    int bad_count, checked;
    assign {frame_start, periodic_done, init_load, control_done, control_list_end, cur_wr_en} = stb;
    hlpr_list_ptr_regs hlpr_list_ptr_regs_inst (.*);
    hlpr_drv_model hlpr_drv_model_inst (.*);
    function automatic logic [31:0] w(input hlpr_addr_t a);
        return {a, 4'h0};
    endfunction : w
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        bad_count += int'(got !== exp);
        if (got !== exp) $display("[ERR] %0t got %h exp %h", $time, got, exp);
    endtask : cmp
    // Strobe for one cycle, then read one register back
    task automatic st(input logic [5:0] s, input logic [7:0] a, input logic [31:0] e);
        @(negedge clk) stb = s;
        @(negedge clk) stb = '0;
        cmp({31'h0, control_list_filled_clear}, {31'h0, s[1] & control_list_filled_flag});
        hlpr_drv_model_inst.rd(a, d, ok);
        cmp({31'h0, ok}, 32'h1);
        cmp(d, e);
    endtask : st
    task automatic tally_and_finish;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        {stb, control_list_enable, control_list_filled_flag, rstn} = '0;
        {periodic_head_addr, periodic_next_addr, shared_comm_area_head} = '0;
        {control_next_addr, cur_wr_addr} = '0;
        void'($urandom(32'h200ca17e));
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        for (int k = 0; k < 5; k++) st('0, 8'h14 + 8'(4 * k), 32'h0);
        for (int i = 0; i < 8; i++) begin
            periodic_head_addr = hlpr_addr_t'($urandom);
            periodic_next_addr = hlpr_addr_t'($urandom);
            shared_comm_area_head = hlpr_addr_t'($urandom);
            control_next_addr = hlpr_addr_t'($urandom);
            cur_wr_addr = hlpr_addr_t'($urandom);
            control_list_enable = i[0];
            control_list_filled_flag = i[1];
            st({1'b1, i[2], 4'h0}, 8'h1c, w(periodic_head_addr));
            st(6'h10, 8'h1c, w(periodic_next_addr));
            st(6'h08, 8'h20, w(shared_comm_area_head));
            cc = w(control_next_addr);
            st(6'h04, 8'h24, cc);
            cc = i[0] ? cc : w(cur_wr_addr);
            st(6'h01, 8'h24, cc);
            st({3'h0, i[2], 2'h2}, 8'h24, i[1] ? w(shared_comm_area_head) : cc);
            $display("test walk %0d done", i);
        end
        tally_and_finish();
    end
endmodule : tb_top
